// file: hw/spf_map.svh
// constants of the serial paged flash write port
// assumes inclusion by bare name from the flash port module source
`ifndef SPF_MAP_SVH
`define SPF_MAP_SVH
`define SPF_WRITE_ENABLE_CMD   8'h06
`define SPF_WRITE_DISABLE_CMD  8'h04
`define SPF_STATUS_READ_CMD    8'h05
`define SPF_PAGE_WRITE_CMD     8'h0a
`define SPF_PAGE_PROGRAM_CMD   8'h02
`define SPF_PAGE_ERASE_CMD     8'hdb
`define SPF_SECTOR_ERASE_CMD   8'hd8
`define SPF_BUSY_BIT           0
`define SPF_WEL_BIT            1
`define SPF_PINS_IDLE          5'h0b
`define SPF_ERASED_BYTE        8'hff
`define SPF_MEM_BYTES          524288
`define SPF_PAGE_BYTES         256
`define SPF_FIFO_DEPTH         8
`define SPF_CLK_MHZ            25
`define SPF_T_PW_US            11000
`define SPF_T_PP_US            1200
`define SPF_T_PE_US            10000
`define SPF_T_SE_US            1000000
`endif

// file: hw/spf_pkg.sv
// types of the serial paged flash write port
// assumes spf_map.svh on the include path
package spf_pkg;
	typedef enum logic [4:0] {
		SPF_IDLE  = 5'h01,
		SPF_MERGE = 5'h02,
		SPF_ERASE = 5'h04,
		SPF_PROG  = 5'h08,
		SPF_WAIT  = 5'h10
	} spf_state_t;
	typedef enum logic [1:0] {
		SPF_OP_PW = 2'h0,
		SPF_OP_PP = 2'h1,
		SPF_OP_PE = 2'h2,
		SPF_OP_SE = 2'h3
	} spf_op_t;
	typedef struct packed {
		logic [7:0] offset;
		logic [7:0] data;
	} spf_wr_t;
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic mosi;
		logic rst_n;
		logic wp_n;
	} spf_pins_t;
endpackage

// file: hw/spf_flash_port.sv
// serial paged flash write port: pin front end, page buffer, write engine
// assumes serial pins asynchronous to clk_sys_i, sclk well below clk/4
//
// Functional notes
// R1: serial output bit changes after each serial clock falling edge.
// R2: instruction, address and data bits captured on serial clock rising edge.
// R3: select high deselects and puts serial output in high impedance.
// R4: deselected with no internal cycle means standby; select low is active.
// R5: no instruction accepted until a select falling edge after power-up; status read is still answered before it.
// R6: reset pin low while idle gives reset state, outputs high impedance.
// R7: reset pin low during an internal cycle leaves that cycle running.
// R8: write protect low refuses modification of the lowest 256 pages.
// R9: write protect high makes the lowest pages modifiable like others.
// R10: both clock idle levels work; rising samples, falling drives.
// R11: master sends write enable, then instruction, three address bytes, data.
// R12: one sequence carries up to 256 bytes inside one page.
// R13: page write is select low, instruction, address, data, select high.
// R14: data bytes enter page buffer starting at the lowest address byte.
// R15: select rising edge ending a page write starts the internal cycle.
// R16: page write merges old page, erases it, then programs from buffer.
// R17: page program only clears bits to zero, never sets erased bits.
// R18: busy flag visible during internal cycles for master polling.
// R19: master should send a whole run of page bytes in one sequence.
// R20: master should hold reset low until supply is valid.
// R21: array is 8 sectors of 256 pages; page or sector erase.
// R22: modifying and enable instructions rejected unless select ends on a byte.
// R23: busy set when cycle begins, cleared when it ends; read-only bits.
// R24: write enable needed; latch cleared by reset, disable, cycle completion.
// R25: everything shifted most significant bit first.
// R26: a buffer byte loaded twice keeps the last value.
`timescale 1ns/1ps
`include "spf_map.svh"

////////////////////////////////////////////////////////////////////////////////
module spf_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rstn_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(D);
	logic [W-1:0] store [0:D-1];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0]   count_reg;
	logic          push;
	logic          pop;

	// depth must be a power of two so the pointers wrap by themselves
	assign in_ready_o  = (count_reg != (AW+1)'(D));
	assign out_valid_o = (count_reg != '0);
	assign out_data_o  = store[rd_ptr_reg];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			store[wr_ptr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module spf_flash_port
	import spf_pkg::*;
#(
	parameter int unsigned PW_CYC = `SPF_T_PW_US * `SPF_CLK_MHZ,
	parameter int unsigned PP_CYC = `SPF_T_PP_US * `SPF_CLK_MHZ,
	parameter int unsigned PE_CYC = `SPF_T_PE_US * `SPF_CLK_MHZ,
	parameter int unsigned SE_CYC = `SPF_T_SE_US * `SPF_CLK_MHZ
) (
	input  wire logic clk_sys_i,
	input  wire logic rstn_i,
	input  wire logic sclk_i,
	input  wire logic cs_n_i,
	input  wire logic mosi_i,
	input  wire logic rst_pin_n_i,
	input  wire logic wp_n_i,
	output logic      miso_o,
	output logic      miso_oe_n_o,
	output logic      busy_o,
	output logic      wel_o,
	output logic      standby_o
);
	logic [7:0]  mem [0:`SPF_MEM_BYTES-1];
	logic [7:0]  page_buf [0:`SPF_PAGE_BYTES-1];
	logic [255:0] loaded_reg;
	spf_pins_t   s1_reg, s2_reg, s3_reg;
	logic        sclk_rise, sclk_fall, cs_fall, cs_rise, sel, pin_rst;
	logic [2:0]  bit_cnt_reg;
	logic [8:0]  byte_cnt_reg;
	logic [7:0]  shift_reg, opcode_reg, offset_reg;
	logic [23:0] addr_reg;
	logic [7:0]  in_byte;
	logic        armed_reg, overrun_reg, wel_reg, busy_reg, start_reg;
	logic        miso_reg, oe_n_reg, standby_reg;
	logic        exec, prot, is_data_op, byte_done;
	spf_op_t     op_reg, op_next;
	logic [18:0] op_addr_reg;
	logic        op_ok;
	spf_state_t  state_reg;
	logic [15:0] idx_reg;
	logic [31:0] timer_reg, dur;
	logic        last_byte, done;
	spf_wr_t     push_data, pop_data;
	logic        push_valid, push_ready, pop_valid, pop_ready;
	logic [18:0] page_addr, erase_addr;
	logic [7:0]  status;
	logic [1:0]  fill_reg;
	logic        pins_ok;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; stage one feeds stage two only
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			s1_reg <= `SPF_PINS_IDLE;
			s2_reg <= `SPF_PINS_IDLE;
			s3_reg <= `SPF_PINS_IDLE;
		end else begin
			s1_reg <= {sclk_i, cs_n_i, mosi_i, rst_pin_n_i, wp_n_i};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// reset values are not the pins; no edges until stage three holds a pin
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			fill_reg <= 2'h0;
		end else if (fill_reg != 2'h3) begin
			fill_reg <= fill_reg + 2'h1;
		end
	end
	assign pins_ok = (fill_reg == 2'h3);

	// edges only; idle clock level never matters
	assign sclk_rise = pins_ok & s2_reg.sclk & ~s3_reg.sclk; // R10
	assign sclk_fall = pins_ok & ~s2_reg.sclk & s3_reg.sclk; // R10
	assign cs_fall   = pins_ok & ~s2_reg.cs_n & s3_reg.cs_n; // R5
	assign cs_rise   = pins_ok & s2_reg.cs_n & ~s3_reg.cs_n;
	assign sel       = ~s2_reg.cs_n & ~pin_rst;
	assign pin_rst   = ~s2_reg.rst_n;
	assign in_byte   = {shift_reg[6:0], s2_reg.mosi}; // R25
	assign byte_done = sel & sclk_rise & (bit_cnt_reg == 3'h7);
	assign is_data_op = (opcode_reg == `SPF_PAGE_WRITE_CMD) ||
		(opcode_reg == `SPF_PAGE_PROGRAM_CMD);

	////////////////////////////////////////////////////////////////////////
	// frame shifter
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i || pin_rst) begin // R6
			bit_cnt_reg  <= 3'h0;
			byte_cnt_reg <= 9'h000;
			shift_reg    <= 8'h00;
			opcode_reg   <= 8'h00;
			addr_reg     <= 24'h000000;
			offset_reg   <= 8'h00;
		end else if (cs_fall) begin
			bit_cnt_reg  <= 3'h0;
			byte_cnt_reg <= 9'h000;
		end else if (sel && sclk_rise) begin
			shift_reg   <= in_byte; // R2
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			if (bit_cnt_reg == 3'h7) begin
				if (byte_cnt_reg != 9'h1ff) begin
					byte_cnt_reg <= byte_cnt_reg + 9'h001;
				end
				if (byte_cnt_reg == 9'h000) begin
					opcode_reg <= in_byte;
				end else if (byte_cnt_reg < 9'h004) begin
					addr_reg <= {addr_reg[15:0], in_byte};
				end
				if (byte_cnt_reg == 9'h003) begin
					offset_reg <= in_byte; // R14
				end else if (push_valid) begin
					offset_reg <= offset_reg + 8'h01; // R12
				end
			end
		end
	end

	// data bytes only while idle; array access during a cycle is ignored
	assign push_valid = byte_done && (byte_cnt_reg >= 9'h004) &&
		is_data_op && !busy_reg && armed_reg;
	assign push_data  = '{offset: offset_reg, data: in_byte};

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			armed_reg   <= 1'b0;
			overrun_reg <= 1'b0;
		end else begin
			if (cs_fall) begin
				armed_reg <= 1'b1; // R5
			end
			// a byte the buffer could not take spoils the whole sequence
			if (push_valid && !push_ready) begin
				overrun_reg <= 1'b1;
			end else if (cs_fall) begin
				overrun_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequence end decode
	assign exec = cs_rise && armed_reg && !pin_rst && !busy_reg &&
		(bit_cnt_reg == 3'h0) && !overrun_reg; // R22
	assign prot = ~s2_reg.wp_n && (addr_reg[18:16] == 3'h0); // R8 R9 R21

	always_comb begin
		op_next = SPF_OP_PW;
		op_ok   = 1'b0;
		case (opcode_reg)
			`SPF_PAGE_WRITE_CMD: begin
				op_next = SPF_OP_PW;
				op_ok   = (byte_cnt_reg >= 9'h005); // R13
			end
			`SPF_PAGE_PROGRAM_CMD: begin
				op_next = SPF_OP_PP;
				op_ok   = (byte_cnt_reg >= 9'h005);
			end
			`SPF_PAGE_ERASE_CMD: begin
				op_next = SPF_OP_PE;
				op_ok   = (byte_cnt_reg == 9'h004); // R21
			end
			`SPF_SECTOR_ERASE_CMD: begin
				op_next = SPF_OP_SE;
				op_ok   = (byte_cnt_reg == 9'h004); // R21
			end
			default: begin
				op_next = SPF_OP_PW;
				op_ok   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i || pin_rst) begin
			wel_reg <= 1'b0; // R24
		end else if (done) begin
			wel_reg <= 1'b0; // R24
		end else if (exec && byte_cnt_reg == 9'h001) begin
			if (opcode_reg == `SPF_WRITE_ENABLE_CMD) begin
				wel_reg <= 1'b1;
			end else if (opcode_reg == `SPF_WRITE_DISABLE_CMD) begin
				wel_reg <= 1'b0; // R24
			end
		end
	end

	// busy and the engine ignore the reset pin so a running cycle completes
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin // R7
			busy_reg    <= 1'b0;
			start_reg   <= 1'b0;
			op_reg      <= SPF_OP_PW;
			op_addr_reg <= 19'h00000;
		end else if (done) begin
			busy_reg <= 1'b0; // R23
		end else if (exec && op_ok && wel_reg && !prot) begin
			busy_reg    <= 1'b1; // R15 R23
			start_reg   <= 1'b1;
			op_reg      <= op_next;
			op_addr_reg <= addr_reg[18:0];
		end else if (state_reg != SPF_IDLE) begin
			start_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// byte path into the page buffer
	spf_fifo #(
		.W ($bits(spf_wr_t)),
		.D (`SPF_FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.rstn_i      (rstn_i),
		.in_valid_i  (push_valid),
		.in_ready_o  (push_ready),
		.in_data_i   (push_data),
		.out_valid_o (pop_valid),
		.out_ready_i (pop_ready),
		.out_data_o  (pop_data)
	);

	// the engine owns the buffer, so draining stalls while it runs
	assign pop_ready = (state_reg == SPF_IDLE);

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i || (cs_fall && !busy_reg)) begin
			loaded_reg <= '0;
		end else if (pop_valid && pop_ready) begin
			loaded_reg[pop_data.offset] <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write engine
	always_comb begin
		case (op_reg)
			SPF_OP_PW: dur = PW_CYC;
			SPF_OP_PP: dur = PP_CYC;
			SPF_OP_PE: dur = PE_CYC;
			default:   dur = SE_CYC;
		endcase
	end

	assign last_byte = (op_reg == SPF_OP_SE && state_reg == SPF_ERASE) ?
		(idx_reg == 16'hffff) : (idx_reg[7:0] == 8'hff);
	assign done       = (state_reg == SPF_WAIT) && (timer_reg >= dur);
	assign page_addr  = {op_addr_reg[18:8], idx_reg[7:0]};
	assign erase_addr = (op_reg == SPF_OP_SE) ?
		{op_addr_reg[18:16], idx_reg} : page_addr;

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			state_reg <= SPF_IDLE;
			idx_reg   <= 16'h0000;
			timer_reg <= 32'h00000000;
		end else begin
			timer_reg <= timer_reg + 32'h00000001;
			idx_reg   <= idx_reg + 16'h0001;
			case (state_reg)
				SPF_IDLE: begin
					idx_reg   <= 16'h0000;
					timer_reg <= 32'h00000000;
					if (start_reg && !pop_valid) begin
						case (op_reg)
							SPF_OP_PW: state_reg <= SPF_MERGE; // R16
							SPF_OP_PP: state_reg <= SPF_PROG;
							default:   state_reg <= SPF_ERASE;
						endcase
					end
				end
				SPF_MERGE: begin
					if (last_byte) begin
						state_reg <= SPF_ERASE; // R16
						idx_reg   <= 16'h0000;
					end
				end
				SPF_ERASE: begin
					if (last_byte) begin
						idx_reg   <= 16'h0000;
						state_reg <= (op_reg == SPF_OP_PW) ?
							SPF_PROG : SPF_WAIT; // R16
					end
				end
				SPF_PROG: begin
					if (last_byte) begin
						state_reg <= SPF_WAIT;
					end
				end
				SPF_WAIT: begin
					if (done) begin
						state_reg <= SPF_IDLE;
					end
				end
				default: begin
					state_reg <= SPF_IDLE;
				end
			endcase
		end
	end

	// array and buffer have no reset; contents are data, not control
	always_ff @(posedge clk_sys_i) begin
		if (pop_valid && pop_ready) begin
			page_buf[pop_data.offset] <= pop_data.data; // R14 R26
		end
		case (state_reg)
			SPF_MERGE: begin
				if (!loaded_reg[idx_reg[7:0]]) begin
					page_buf[idx_reg[7:0]] <= mem[page_addr]; // R16
				end
			end
			SPF_ERASE: begin
				mem[erase_addr] <= `SPF_ERASED_BYTE; // R21
			end
			SPF_PROG: begin
				if (op_reg == SPF_OP_PW) begin
					mem[page_addr] <= page_buf[idx_reg[7:0]]; // R16
				end else if (loaded_reg[idx_reg[7:0]]) begin
					mem[page_addr] <= mem[page_addr] &
						page_buf[idx_reg[7:0]]; // R17
				end
			end
			default: begin
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// serial output and status pins
	always_comb begin
		status = 8'h00;
		status[`SPF_BUSY_BIT] = busy_reg; // R18
		status[`SPF_WEL_BIT]  = wel_reg;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			miso_reg    <= 1'b0;
			oe_n_reg    <= 1'b1;
			standby_reg <= 1'b1;
		end else begin
			oe_n_reg    <= ~sel; // R3 R6
			standby_reg <= s2_reg.cs_n & ~busy_reg; // R4
			if (sel && sclk_fall && byte_cnt_reg != 9'h000 &&
				opcode_reg == `SPF_STATUS_READ_CMD) begin
				miso_reg <= status[~bit_cnt_reg]; // R1 R25
			end
		end
	end

	assign miso_o      = miso_reg;
	assign miso_oe_n_o = oe_n_reg;
	assign busy_o      = busy_reg;
	assign wel_o       = wel_reg;
	assign standby_o   = standby_reg;
endmodule

// file: verif/spf_flash_port_chk.sv
// pin-level assertions for the serial paged flash write port
// assumes a bind onto spf_flash_port, one clock domain
`timescale 1ns/1ps
module spf_flash_port_chk #(
	parameter int unsigned PW_CYC = 1000,
	parameter int unsigned PP_CYC = 400,
	parameter int unsigned PE_CYC = 400,
	parameter int unsigned SE_CYC = 70000
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	input wire logic rst_pin_n_i,
	input wire logic wp_n_i,
	input wire logic miso_o,
	input wire logic miso_oe_n_o,
	input wire logic busy_o,
	input wire logic wel_o,
	input wire logic standby_o
);
	localparam int unsigned MIN_BUSY = (PP_CYC < PE_CYC) ? PP_CYC : PE_CYC;
	localparam int unsigned MAX_BUSY = SE_CYC + 16;
	logic [31:0] busy_cnt_reg;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);

	////////////////////////////////////////////////////////////////////////
	// length of the current busy run
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i || !busy_o)
			busy_cnt_reg <= 32'h0;
		else
			busy_cnt_reg <= busy_cnt_reg + 32'h1;
	end

	// six samples leave room for the pin synchronisers
	sequence s_desel;
		cs_n_i [*6];
	endsequence
	sequence s_sel;
		!cs_n_i [*6];
	endsequence
	sequence s_pin_rst;
		!rst_pin_n_i [*6];
	endsequence
	sequence s_quiet;
		(cs_n_i && !busy_o) [*6];
	endsequence

	////////////////////////////////////////////////////////////////////////
	a_oe_desel: assert property (s_desel |-> miso_oe_n_o)
		else $error("serial output driven while deselected");
	a_oe_pin_rst: assert property (s_pin_rst |-> miso_oe_n_o)
		else $error("serial output driven during pin reset");
	a_standby_on: assert property (s_quiet |-> standby_o)
		else $error("no standby while deselected and idle");
	a_active_sel: assert property (s_sel |-> !standby_o)
		else $error("standby while selected");
	a_busy_min: assert property ($fell(busy_o) |->
		busy_cnt_reg >= MIN_BUSY - 2)
		else $error("internal cycle ended too early");
	a_busy_max: assert property (busy_o |-> busy_cnt_reg <= MAX_BUSY)
		else $error("busy flag never cleared");
	a_wel_done: assert property ($fell(busy_o) |-> !wel_o)
		else $error("latch still set after cycle end");
	a_busy_wel: assert property ($rose(busy_o) |-> $past(wel_o))
		else $error("cycle started without write enable");
	a_busy_cs: assert property ($rose(busy_o) |->
		cs_n_i && $past(cs_n_i, 3))
		else $error("cycle started while selected");
	a_wel_pin_rst: assert property (s_pin_rst |-> !wel_o)
		else $error("latch kept through pin reset");
endmodule

// file: verif/spf_master.sv
// serial bus master model driving the flash write port, mode 0 or 3
// assumes clk_sys_i only to place frame starts; link period 320 ns
`timescale 1ns/1ps
module spf_master (
	input  wire logic clk_sys_i,
	input  wire logic sdo_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o
);
	logic cpol;

	// select low from power-up, so the first frame has no falling edge
	initial begin
		cpol   = 1'b0;
		sclk_o = 1'b0;
		cs_n_o = 1'b0;
		mosi_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic xfer(input logic [95:0] d, input int n,
		output logic [7:0] rx);
		int i;
		rx = 8'h00;
		@(posedge clk_sys_i);
		#7;
		sclk_o = cpol;
		cs_n_o = 1'b0;
		#160;
		for (i = n - 1; i >= 0; i--) begin
			sclk_o = 1'b0;
			mosi_o = d[i];
			#160;
			sclk_o = 1'b1;
			rx = {rx[6:0], sdo_i};
			#160;
		end
		sclk_o = cpol;
		#160;
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		#480;
	endtask
endmodule

// file: verif/test_serial_paged_flash_write_port.sv
// bench top: clock, resets, frames through the master model, scoreboard
// assumes spf_master and spf_flash_port_chk compiled before this file
`timescale 1ns/1ps
module test_serial_paged_flash_write_port;
	localparam int unsigned PW_CYC = 1000;
	localparam int unsigned PP_CYC = 400;
	localparam int unsigned PE_CYC = 400;
	localparam int unsigned SE_CYC = 70000;
	localparam logic [95:0] PP_FRM = {56'h0, 8'h02, 24'h001234, 8'h5a};
	logic        clk_sys_i, rstn_i, rst_pin_n_i, wp_n_i;
	logic        sclk, cs_n, mosi, miso, miso_oe_n, busy, write_enable_latch, standby;
	logic        miso_line;
	logic [7:0]  got, exp_v, rx;
	logic [7:0]  note_q[$];
	logic [95:0] d;
	int          n_errors, n_compared, i, nb;
	event        ev_chk;

	// released line shows the inverse, never a stale level
	assign miso_line = miso_oe_n ? ~miso : miso;

	spf_flash_port #(.PW_CYC(PW_CYC), .PP_CYC(PP_CYC), .PE_CYC(PE_CYC),
		.SE_CYC(SE_CYC)) u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
		.rst_pin_n_i(rst_pin_n_i), .wp_n_i(wp_n_i), .miso_o(miso),
		.miso_oe_n_o(miso_oe_n), .busy_o(busy), .wel_o(write_enable_latch),
		.standby_o(standby));
	spf_master u_mst (.clk_sys_i(clk_sys_i), .sdo_i(miso_line),
		.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	////////////////////////////////////////////////////////////////////////
	always @(ev_chk) begin
		exp_v = note_q.pop_front();
		n_compared++;
		if (got !== exp_v) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp_v);
		end
	end

	task automatic look(input logic [7:0] a, input logic [7:0] e);
		note_q.push_back(e);
		got = a;
		->ev_chk;
		@(posedge clk_sys_i);
	endtask
	task automatic pin(input logic [7:0] e);
		#7;
		look({6'h00, write_enable_latch, busy}, e);
	endtask
	task automatic cmd(input logic [95:0] dd, input int n);
		u_mst.xfer(dd, n, rx);
	endtask
	task automatic stat(input logic [7:0] e);
		u_mst.xfer({80'h0, 8'h05, 8'h00}, 16, rx);
		look(rx, e);
	endtask
	task automatic wait_idle(input int lim);
		for (i = 0; i < lim && busy !== 1'b0; i++)
			@(posedge clk_sys_i);
	endtask
	task automatic stop_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#4000000;
		n_errors++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		rstn_i = 1'b0;
		rst_pin_n_i = 1'b0;
		wp_n_i = 1'b1;
		n_errors = 0;
		n_compared = 0;
		void'($urandom(32'h4397));
		repeat (12) @(posedge clk_sys_i);
		#7;
		rstn_i = 1'b1;
		rst_pin_n_i = 1'b1;
		repeat (4) @(posedge clk_sys_i);
		pin(8'h00);
		cmd(96'h06, 8);
		pin(8'h00);
		cmd(96'h06, 8);
		pin(8'h02);
		cmd(96'h04, 8);
		pin(8'h00);
		cmd(96'h0c, 9);
		pin(8'h00);
		cmd(96'h06, 8);
		#7;
		wp_n_i = 1'b0;
		cmd(PP_FRM, 40);
		pin(8'h02);
		#7;
		wp_n_i = 1'b1;
		cmd(PP_FRM, 40);
		pin(8'h03);
		stat(8'h03);
		wait_idle(PP_CYC + 100);
		pin(8'h00);
		stat(8'h00);
		// page write with a random run of bytes inside one page
		nb = 1 + $urandom % 8;
		d = 96'h0;
		d[31:0] = {8'h0a, 16'h0300, 8'($urandom % 248)};
		for (i = 0; i < nb; i++)
			d = {d[87:0], 8'($urandom)};
		cmd(96'h06, 8);
		cmd(d, 32 + 8 * nb);
		pin(8'h03);
		cmd(96'h04, 8);
		pin(8'h03);
		#7;
		rst_pin_n_i = 1'b0;
		repeat (8) @(posedge clk_sys_i);
		pin(8'h01);
		#7;
		rst_pin_n_i = 1'b1;
		wait_idle(PW_CYC + 100);
		pin(8'h00);
		// mode 3 for page and sector erase
		u_mst.cpol = 1'b1;
		cmd(96'h06, 8);
		cmd({64'h0, 8'hdb, 24'h050100}, 32);
		pin(8'h03);
		wait_idle(PE_CYC + 100);
		pin(8'h00);
		stat(8'h00);
		cmd(96'h06, 8);
		cmd({64'h0, 8'hd8, 24'h070000}, 32);
		pin(8'h03);
		wait_idle(SE_CYC + 100);
		pin(8'h00);
		stop_test();
	end
endmodule

bind spf_flash_port spf_flash_port_chk #(.PW_CYC(PW_CYC), .PP_CYC(PP_CYC),
	.PE_CYC(PE_CYC), .SE_CYC(SE_CYC)) u_chk (.clk_sys_i(clk_sys_i),
	.rstn_i(rstn_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .mosi_i(mosi_i),
	.rst_pin_n_i(rst_pin_n_i), .wp_n_i(wp_n_i), .miso_o(miso_o),
	.miso_oe_n_o(miso_oe_n_o), .busy_o(busy_o), .wel_o(wel_o),
	.standby_o(standby_o));
